/* pkg/asc_pkg.sv */
/*
  Package for the host-side controller of an asynchronous 1024 x 4 static RAM.
  Assumes a 10 MHz system clock; all pin timing is expressed in whole cycles.
*/
package asc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ASC_AW = 10;
  localparam int ASC_DW = 4;

  // ----------------------------------------------------------------
  // Timing, in ns or us as printed, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int ASC_CLK_NS = 100;
  localparam int ASC_POWERUP_US = 500;
  localparam int ASC_POWERUP_CYC = (ASC_POWERUP_US * 1000 + ASC_CLK_NS - 1) / ASC_CLK_NS;
  // Slowest grade figures, so any grade is met
  localparam int ASC_ADDR_BEFORE_WEND_NS = 65;
  localparam int ASC_SEL_ACCESS_SHORT_NS = 80;
  localparam int ASC_SEL_IDLE_NS = 55;
  localparam int ASC_WRITE_RECOVERY_NS = 5;
  localparam int ASC_FLOAT_NS = 25;
  localparam int ASC_WCYC = (ASC_ADDR_BEFORE_WEND_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
  localparam int ASC_RCYC = (ASC_SEL_ACCESS_SHORT_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
  localparam int ASC_IDLE_CYC = (ASC_SEL_IDLE_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
  localparam int ASC_TURN_CYC = (ASC_FLOAT_NS + ASC_CLK_NS - 1) / ASC_CLK_NS;
  // Edges the line synchroniser adds before read data can be taken
  localparam int ASC_SYNC_CYC = 2;
  localparam int ASC_CW = 13;

  // ----------------------------------------------------------------
  // Request and pin bundles
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [ASC_AW-1:0] addr;
    logic [ASC_DW-1:0] data;
  } asc_req_t;

  typedef struct packed {
    logic sel_n;
    logic wstb_n;
    logic [ASC_AW-1:0] word_address;
    logic [ASC_DW-1:0] dq_out;
    logic [ASC_DW-1:0] dq_oe_n;
  } asc_pins_t;

endpackage

/* src/asc_ctrl.sv */
/*
  Host controller for an asynchronous 1024 x 4 SRAM with shared data lines.
  Assumes a 10 MHz clock, synchronous low reset, and a pad ring that resolves
  the data lines from o_dq_out and o_dq_oe_n.
*/
// Function
// - Selected with strobe low the host drives the lines and the memory stores them.
// - The host releases the lines for reads, the memory releases them for writes.
// - The host starts no access until 500 us after power-up.
// - The host sets the address no later than the falling edge of select.
// - The host keeps the write address valid long enough before the write ends.
// - The host keeps strobe or select high whenever the address changes.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int POWERUP_CYC = ASC_POWERUP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_req_valid,
  input wire asc_req_t i_req,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [ASC_DW-1:0] o_rd_data,
  output logic o_sel_n,
  output logic o_wstb_n,
  output logic [ASC_AW-1:0] o_word_address,
  output logic [ASC_DW-1:0] o_dq_out,
  output logic [ASC_DW-1:0] o_dq_oe_n,
  input wire logic [ASC_DW-1:0] i_dq_in
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_PWR, S_IDLE, S_SETUP, S_WRITE, S_READ, S_CAPT, S_GAP} asc_state_t;

  asc_state_t state_q, state_d;
  logic [ASC_CW-1:0] cnt_q, cnt_d;
  asc_pins_t pins_q, pins_d;
  logic wr_q, wr_d;
  logic rd_valid_q, rd_valid_d;
  logic [ASC_DW-1:0] rd_data_q, rd_data_d;
  logic [ASC_DW-1:0] dq_sync;
  wire cnt_done = (cnt_q == '0);
  wire accept = (state_q == S_IDLE) && i_req_valid;

  // The lines come from pins, so only the synchronised copy is ever read
  asc_sync2 #(.W(ASC_DW)) u_sync (
    .i_mclk(i_mclk),
    .i_d(i_dq_in),
    .o_q(dq_sync)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Reads wait the full access time plus two synchroniser cycles, trading speed
  // for a design that never samples the pins asynchronously.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
    pins_d = pins_q;
    wr_d = wr_q;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    unique case (state_q)
      S_PWR: begin
        if (cnt_done) begin
          state_d = S_IDLE;
        end
      end
      S_IDLE: begin
        if (accept) begin
          // Address changes only with select high.
          pins_d.word_address = i_req.addr;
          pins_d.dq_out = i_req.data;
          wr_d = i_req.wr;
          state_d = S_SETUP;
        end
      end
      S_SETUP: begin
        pins_d.sel_n = 1'b0;
        if (wr_q) begin
          pins_d.wstb_n = 1'b0;
          pins_d.dq_oe_n = '0;
          cnt_d = ASC_CW'(ASC_WCYC + ASC_TURN_CYC);
          state_d = S_WRITE;
        end else begin
          cnt_d = ASC_CW'(ASC_RCYC);
          state_d = S_READ;
        end
      end
      S_WRITE: begin
        if (cnt_done) begin
          // Strobe and select rise together, data held through that edge.
          pins_d.wstb_n = 1'b1;
          pins_d.sel_n = 1'b1;
          cnt_d = ASC_CW'(ASC_IDLE_CYC + ASC_WRITE_RECOVERY_NS / ASC_CLK_NS);
          state_d = S_GAP;
        end
      end
      S_READ: begin
        if (cnt_done) begin
          cnt_d = ASC_CW'(ASC_SYNC_CYC);
          state_d = S_CAPT;
        end
      end
      S_CAPT: begin
        if (cnt_done) begin
          rd_data_d = dq_sync;
          rd_valid_d = 1'b1;
          pins_d.sel_n = 1'b1;
          cnt_d = ASC_CW'(ASC_IDLE_CYC);
          state_d = S_GAP;
        end
      end
      S_GAP: begin
        // Released one cycle after the strobe rises, so data hold spans that edge
        pins_d.dq_oe_n = '1;
        if (cnt_done) begin
          state_d = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state_q <= S_PWR;
      cnt_q <= ASC_CW'(POWERUP_CYC);
      pins_q <= '{sel_n: 1'b1, wstb_n: 1'b1, word_address: '0, dq_out: '0, dq_oe_n: '1};
      wr_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      wr_q <= wr_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_req_ready = (state_q == S_IDLE);
  assign o_rd_valid = rd_valid_q;
  assign o_rd_data = rd_data_q;
  assign o_sel_n = pins_q.sel_n;
  assign o_wstb_n = pins_q.wstb_n;
  assign o_word_address = pins_q.word_address;
  assign o_dq_out = pins_q.dq_out;
  assign o_dq_oe_n = pins_q.dq_oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Host-side pin order only; the memory has no clock, so its own timing
  // is neither asserted here nor modelled by the zero-delay bench model.
  chk_addr_stable_sel: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !$stable(o_word_address) |-> $past(o_sel_n) && o_sel_n)
    else $error("address moved while selected");
  chk_no_drive_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (!o_sel_n && o_wstb_n) |-> o_dq_oe_n == '1)
    else $error("host drives lines during read");
  chk_drive_write: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !o_wstb_n |-> (o_dq_oe_n == '0) && !o_sel_n)
    else $error("write strobe without data or select");
  chk_wstb_sel_only: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $rose(o_wstb_n) |-> $rose(o_sel_n))
    else $error("strobe and select did not rise together");
  chk_write_len: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $fell(o_wstb_n) |-> !o_wstb_n [*2])
    else $error("write pulse too short");
  chk_read_access: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    ($fell(o_sel_n) && o_wstb_n) |-> !o_sel_n [*4])
    else $error("read select too short");
  chk_read_result: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    ($fell(o_sel_n) && o_wstb_n) |-> ##5 o_rd_valid)
    else $error("read data not returned on time");
  chk_idle_gap: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $rose(o_sel_n) |-> o_sel_n [*2])
    else $error("deselect gap too short");
  chk_powerup_quiet: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (state_q == S_PWR) |-> o_sel_n && !o_req_ready)
    else $error("access during power-up wait");
  chk_addr_at_select: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $fell(o_sel_n) |-> $stable(o_word_address) && $stable(o_dq_out))
    else $error("address not settled at select fall");
  chk_strobe_with_sel: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $fell(o_wstb_n) |-> $fell(o_sel_n))
    else $error("strobe fell without select");
  chk_data_hold_end: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $rose(o_wstb_n) |-> (o_dq_oe_n == '0) && $stable(o_dq_out))
    else $error("write data dropped at strobe rise");
  chk_release_after: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $rose(o_wstb_n) |-> ##1 (o_dq_oe_n == '1))
    else $error("lines not released after write");
  chk_drive_window: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (o_dq_oe_n != '1) |-> !o_wstb_n || !$past(o_wstb_n))
    else $error("host drives lines outside a write");
  chk_rd_valid_pulse: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_rd_valid |=> !o_rd_valid)
    else $error("read valid held too long");
  chk_idle_quiet: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_req_ready |-> o_sel_n && o_wstb_n && (o_dq_oe_n == '1))
    else $error("pins active while idle");

endmodule // asc_ctrl
`default_nettype wire

/* src/asc_sync2.sv */
/*
  Two-flop synchroniser for the shared data lines.
  Assumes the input comes from pins outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module asc_sync2 #(
  parameter int W = 4
) (
  input wire logic i_mclk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_mclk) begin
    meta_q <= i_d;
    sync_q <= meta_q;
  end

  assign o_q = sync_q;
endmodule // asc_sync2
`default_nettype wire

/* tb/asc_ctrl_test.sv */
/*
  Self-checking bench for the SRAM host controller.
  Assumes asc_ctrl and asc_sram_model; inputs change by NBA at rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_test
  import asc_pkg::*;
;
  typedef struct packed {asc_req_t r; logic [ASC_DW-1:0] e;} asc_row_t;
  localparam int PUC = 4;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic req_valid = 1'b0;
  asc_req_t req = '0;
  logic req_ready, rd_valid, sel_n, wstb_n, mem_oe_n, sel_p, wstb_p;
  logic [ASC_DW-1:0] rd_data, dq_out, dq_oe_n, mem_dq, dq;
  logic [ASC_DW-1:0] last_q = '0;
  logic [ASC_AW-1:0] addr, addr_p;
  int err_count = 0;
  int tests_run = 0;
  int low_cyc = 0;
  asc_row_t rows [11] = '{
    '{'{1'b1, 10'h000, 4'h5}, 4'h0}, '{'{1'b1, 10'h3ff, 4'ha}, 4'h0}, '{'{1'b1, 10'h155, 4'h3}, 4'h0},
    '{'{1'b0, 10'h155, 4'h0}, 4'h3}, '{'{1'b1, 10'h155, 4'hc}, 4'h0}, '{'{1'b0, 10'h155, 4'h0}, 4'hc},
    '{'{1'b0, 10'h155, 4'h0}, 4'hc}, '{'{1'b0, 10'h000, 4'h0}, 4'h5}, '{'{1'b0, 10'h3ff, 4'h0}, 4'ha},
    '{'{1'b1, 10'h2aa, 4'h0}, 4'h0}, '{'{1'b0, 10'h2aa, 4'h0}, 4'h0}};

  initial begin
    forever #50 i_mclk = ~i_mclk;
  end
  // Undriven lines show the inverse of their last level, so stale data never reads right
  assign dq = (dq_out & ~dq_oe_n) | (mem_dq & dq_oe_n & {ASC_DW{~mem_oe_n}})
    | (~last_q & dq_oe_n & {ASC_DW{mem_oe_n}});

  asc_ctrl #(.POWERUP_CYC(PUC)) i_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(req_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_sel_n(sel_n), .o_wstb_n(wstb_n),
    .o_word_address(addr), .o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .i_dq_in(dq));
  asc_sram_model i_mem (.i_sel_n(sel_n), .i_wstb_n(wstb_n), .i_word_address(addr), .i_dq(dq), .o_dq(mem_dq),
    .o_dq_oe_n(mem_oe_n));

  // ----------------------------------------------------------------
  // Checks and pin watch
  // ----------------------------------------------------------------
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_data(input string nm, input logic [ASC_DW-1:0] e, input logic [ASC_DW-1:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge i_mclk) begin
    if (!mem_oe_n || !(&dq_oe_n)) last_q <= dq;
    addr_p <= addr;
    sel_p <= sel_n;
    wstb_p <= wstb_n;
    low_cyc <= (!sel_n && !wstb_n) ? low_cyc + 1 : 0;
    if (i_nrst) begin
      chk_bit("bus_free", 1'b1, mem_oe_n | (&dq_oe_n));
      if (addr !== addr_p) chk_bit("addr_quiet", 1'b1, sel_p && sel_n);
      if (low_cyc > 0 && (sel_n || wstb_n)) begin
        chk_bit("write_len", 1'b1, low_cyc >= ASC_WCYC);
        chk_bit("rise_together", 1'b1, sel_n && wstb_n);
      end
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic send(input asc_req_t r, input logic [ASC_DW-1:0] e);
    int n;
    n = 0;
    @(posedge i_mclk);
    req_valid <= 1'b1;
    req <= r;
    do begin
      @(posedge i_mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    chk_bit("req_taken", 1'b1, req_ready);
    if (!r.wr) begin
      n = 0;
      do begin
        @(posedge i_mclk);
        n++;
      end while (rd_valid !== 1'b1 && n < 20);
      chk_bit("rd_valid", 1'b1, rd_valid);
      chk_data("rd_data", e, rd_data);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    int n;
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
      if (req_ready !== 1'b1) chk_bit("idle_sel_n", 1'b1, sel_n);
    end while (req_ready !== 1'b1 && n < 20);
    chk_bit("powerup_wait", 1'b1, n >= PUC - 1 && n <= PUC + 2);
    $display("test reset done");
    foreach (rows[i]) send(rows[i].r, rows[i].e);
    $display("test table done");
    send('{1'b1, 10'h100, 4'h9}, 4'h0);
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk_bit("rst_sel_n", 1'b1, sel_n);
    chk_bit("rst_wstb_n", 1'b1, wstb_n);
    chk_data("rst_oe_n", 4'hf, dq_oe_n);
    i_nrst <= 1'b1;
    send('{1'b0, 10'h3ff, 4'h0}, 4'ha);
    $display("test midreset done");
    wrap_up();
  end
  // About 120 cycles of traffic; over sixteen times that means a hang
  initial begin
    #(ASC_CLK_NS * 2000);
    err_count++;
    wrap_up();
  end
endmodule // asc_ctrl_test
`default_nettype wire

/* tb/asc_sram_model.sv */
/*
  Behavioural model of the 1024 x 4 static RAM beside the controller.
  Assumes the bench resolves the shared data lines and feeds them back in.
*/
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model
  import asc_pkg::*;
(
  input wire logic i_sel_n,
  input wire logic i_wstb_n,
  input wire logic [ASC_AW-1:0] i_word_address,
  input wire logic [ASC_DW-1:0] i_dq,
  output logic [ASC_DW-1:0] o_dq,
  output logic o_dq_oe_n
);
  // ----------------------------------------------------------------
  // Storage and pins
  // ----------------------------------------------------------------
  logic [ASC_DW-1:0] mem_q [0:(1<<ASC_AW)-1];
  // Level store: an address moved mid-write corrupts words, as the real part would
  always @(i_sel_n or i_wstb_n or i_word_address or i_dq) begin
    if (!i_sel_n && !i_wstb_n) begin
      mem_q[i_word_address] = i_dq;
    end
  end
  // Zero delay: access is immediate and old data lasts until the address moves,
  // so the bench cannot show the host's fixed waits meet any grade's access and hold times
  assign o_dq = mem_q[i_word_address];
  assign o_dq_oe_n = i_sel_n | !i_wstb_n;
endmodule // asc_sram_model
`default_nettype wire
